// ===== tgc_pkg.sv
`default_nettype none

// Register map, field layout and encodings of the gate control block
package tgc_pkg;

   // Byte addresses of the word-aligned registers
   localparam logic [7:0] TGC_ADDR_GATE_CONTROL = 8'h00;
   localparam logic [7:0] TGC_ADDR_COUNT_LOW    = 8'h04;
   localparam logic [7:0] TGC_ADDR_COUNT_HIGH   = 8'h08;
   localparam logic [7:0] TGC_ADDR_COUNTER_CTRL = 8'h0C;
   localparam logic [7:0] TGC_ADDR_INT_STATUS   = 8'h10;
   localparam logic [7:0] TGC_ADDR_INT_MASK     = 8'h14;

   // Field positions of gate_control
   localparam int TGC_BIT_GATE_ENABLE   = 7;
   localparam int TGC_BIT_GATE_POLARITY = 6;
   localparam int TGC_BIT_TOGGLE_MODE   = 5;
   localparam int TGC_BIT_SINGLE_PULSE  = 4;
   localparam int TGC_BIT_GO_FLAG       = 3;
   localparam int TGC_BIT_GATE_LEVEL    = 2;
   localparam int TGC_SRC_HI            = 1;
   localparam int TGC_SRC_LO            = 0;

   // Field positions of counter_ctrl and of the interrupt registers
   localparam int TGC_BIT_COUNTER_ON    = 0;
   localparam int TGC_INT_OVERFLOW      = 0;
   localparam int TGC_INT_ACQ_DONE      = 1;
   localparam int TGC_INT_W             = 2;

   // Reset values
   localparam logic [7:0]  TGC_RST_GATE_CONTROL = 8'h00;
   localparam logic [15:0] TGC_RST_COUNT        = 16'h0000;
   localparam logic [1:0]  TGC_RST_INT          = 2'h0;

   // Gate source codes
   localparam logic [1:0] TGC_SRC_PIN        = 2'h0;
   localparam logic [1:0] TGC_SRC_TIMER_OVF  = 2'h1;
   localparam logic [1:0] TGC_SRC_COMPARATOR = 2'h2;

   // AHB-Lite encodings
   localparam logic [1:0] TGC_HTRANS_NONSEQ = 2'h2;

   // Single-pulse acquisition states
   typedef enum logic [2:0] {
      TGC_SP_IDLE = 3'b001,
      TGC_SP_WAIT = 3'b010,
      TGC_SP_MEAS = 3'b100
   } tgc_sp_e;

endpackage

`default_nettype wire

// ===== tgc_top.sv
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

module tgc_top #(
   parameter int COUNT_W = 16
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        gate_pin,
   input  wire logic        other_timer_ovf,
   input  wire logic        comparator_sync_output,
   input  wire logic        count_tick,
   output logic             irq
);

   // Two byte registers cover exactly sixteen bits
   if (COUNT_W != 16) begin : g_check
      $error("tgc_top: COUNT_W must be 16");
   end

   typedef struct packed {
      logic [2:0]         pin_sync;
      logic               pin_level;
      logic               pol_prev;
      logic               path_prev;
      logic               toggle_ff;
      tgc_pkg::tgc_sp_e   sp_state;
      logic [7:0]         gate_control;
      logic               counter_on;
      logic [COUNT_W-1:0] count;
      logic [tgc_pkg::TGC_INT_W-1:0] int_status;
      logic [tgc_pkg::TGC_INT_W-1:0] int_mask;
      logic               irq;
      logic               wr_pend;
      logic [7:0]         wr_addr;
      logic [31:0]        rdata;
   } tgc_state_s;

   tgc_state_s s_q;
   tgc_state_s s_d;

   // Gate source decode, reserved code gives a low source level
   function automatic logic tgc_source_level(input logic [1:0] sel, input logic pin,
                                             input logic ovf, input logic cmp);
      case (sel)
         tgc_pkg::TGC_SRC_PIN:        tgc_source_level = pin;
         tgc_pkg::TGC_SRC_TIMER_OVF:  tgc_source_level = ovf;
         tgc_pkg::TGC_SRC_COMPARATOR: tgc_source_level = cmp;
         default:                     tgc_source_level = 1'b0;
      endcase
   endfunction

   // Control fields
   logic       ge;
   logic       pol;
   logic       tm;
   logic       spm;
   logic       go;
   logic [1:0] ss;
   assign ge  = s_q.gate_control[tgc_pkg::TGC_BIT_GATE_ENABLE];
   assign pol = s_q.gate_control[tgc_pkg::TGC_BIT_GATE_POLARITY];
   assign tm  = s_q.gate_control[tgc_pkg::TGC_BIT_TOGGLE_MODE];
   assign spm = s_q.gate_control[tgc_pkg::TGC_BIT_SINGLE_PULSE];
   assign go  = s_q.gate_control[tgc_pkg::TGC_BIT_GO_FLAG];
   assign ss  = s_q.gate_control[tgc_pkg::TGC_SRC_HI:tgc_pkg::TGC_SRC_LO];

   // Gate path: source, polarity, toggle, single pulse
   logic sel_level;
   logic pol_level;
   logic pol_rise;
   logic path_level;
   logic path_rise;
   logic path_fall;
   logic sp_gate;
   logic proc_gate;
   assign sel_level  = tgc_source_level(ss, s_q.pin_level, other_timer_ovf,
                                        comparator_sync_output);
   assign pol_level  = pol ? sel_level : ~sel_level;
   assign pol_rise   = pol_level & ~s_q.pol_prev;
   assign path_level = tm ? s_q.toggle_ff : pol_level;
   assign path_rise  = path_level & ~s_q.path_prev;
   assign path_fall  = ~path_level & s_q.path_prev;
   assign sp_gate    = (s_q.sp_state == tgc_pkg::TGC_SP_MEAS);
   assign proc_gate  = spm ? sp_gate : path_level;

   // Bus address phase and data phase decode
   logic       acc;
   logic       rd_acc;
   logic [7:0] a_addr;
   logic       wr_gc;
   logic       wr_lo;
   logic       wr_hi;
   logic       wr_cc;
   logic       wr_mask;
   logic       go_set_wr;
   assign acc       = hsel & hready & (htrans == tgc_pkg::TGC_HTRANS_NONSEQ);
   assign rd_acc    = acc & ~hwrite;
   assign a_addr    = haddr[7:0];
   assign wr_gc     = s_q.wr_pend & (s_q.wr_addr == tgc_pkg::TGC_ADDR_GATE_CONTROL);
   assign wr_lo     = s_q.wr_pend & (s_q.wr_addr == tgc_pkg::TGC_ADDR_COUNT_LOW);
   assign wr_hi     = s_q.wr_pend & (s_q.wr_addr == tgc_pkg::TGC_ADDR_COUNT_HIGH);
   assign wr_cc     = s_q.wr_pend & (s_q.wr_addr == tgc_pkg::TGC_ADDR_COUNTER_CTRL);
   assign wr_mask   = s_q.wr_pend & (s_q.wr_addr == tgc_pkg::TGC_ADDR_INT_MASK);
   assign go_set_wr = wr_gc & hwdata[tgc_pkg::TGC_BIT_GO_FLAG];

   // Counter advance condition
   logic advance;
   logic overflow;
   logic acq_done;
   assign advance  = s_q.counter_on & count_tick & (~ge | proc_gate);
   assign overflow = advance & (&s_q.count) & ~(wr_lo | wr_hi);
   assign acq_done = spm & go & sp_gate & path_fall;

   // Next-state logic for the whole block
   always_comb begin
      logic [7:0] rv;
      rv = 8'h00;
      s_d = s_q;
      // Pin synchroniser; a change counts once stages two and three agree
      s_d.pin_sync = {s_q.pin_sync[1:0], gate_pin};
      if (s_q.pin_sync[1] == s_q.pin_sync[2]) begin
         s_d.pin_level = s_q.pin_sync[2];
      end
      s_d.pol_prev  = pol_level;
      s_d.path_prev = path_level;
      // Toggle stage
      if (!tm) begin
         s_d.toggle_ff = 1'b0;
      end else if (pol_rise) begin
         s_d.toggle_ff = ~s_q.toggle_ff;
      end
      // Single-pulse acquisition; abort when disabled or go cleared
      case (s_q.sp_state)
         tgc_pkg::TGC_SP_IDLE: begin
            if (spm && go) begin
               s_d.sp_state = tgc_pkg::TGC_SP_WAIT;
            end
         end
         tgc_pkg::TGC_SP_WAIT: begin
            if (!spm || !go) begin
               s_d.sp_state = tgc_pkg::TGC_SP_IDLE;
            end else if (path_rise) begin
               s_d.sp_state = tgc_pkg::TGC_SP_MEAS;
            end
         end
         tgc_pkg::TGC_SP_MEAS: begin
            if (!spm || !go || path_fall) begin
               s_d.sp_state = tgc_pkg::TGC_SP_IDLE;
            end
         end
         default: s_d.sp_state = tgc_pkg::TGC_SP_IDLE;
      endcase
      // Gate control write; level bit is read-only, set by software wins
      if (wr_gc) begin
         s_d.gate_control = hwdata[7:0];
         s_d.gate_control[tgc_pkg::TGC_BIT_GATE_LEVEL] = 1'b0;
      end
      if (acq_done && !go_set_wr) begin
         s_d.gate_control[tgc_pkg::TGC_BIT_GO_FLAG] = 1'b0;
      end
      if (wr_cc) begin
         s_d.counter_on = hwdata[tgc_pkg::TGC_BIT_COUNTER_ON];
      end
      // Counter; a byte write takes precedence over counting
      if (wr_lo) begin
         s_d.count[7:0] = hwdata[7:0];
      end else if (wr_hi) begin
         s_d.count[15:8] = hwdata[7:0];
      end else if (advance) begin
         s_d.count = s_q.count + 16'h0001;
      end
      if (wr_mask) begin
         s_d.int_mask = hwdata[tgc_pkg::TGC_INT_W-1:0];
      end
      // Status cleared by its read, events set after so they win
      if (rd_acc && a_addr == tgc_pkg::TGC_ADDR_INT_STATUS) begin
         s_d.int_status = tgc_pkg::TGC_RST_INT;
      end
      if (overflow) begin
         s_d.int_status[tgc_pkg::TGC_INT_OVERFLOW] = 1'b1;
      end
      if (acq_done) begin
         s_d.int_status[tgc_pkg::TGC_INT_ACQ_DONE] = 1'b1;
      end
      s_d.irq = |(s_d.int_status & s_d.int_mask);
      // Read data captured in the address phase
      case (a_addr)
         tgc_pkg::TGC_ADDR_GATE_CONTROL: begin
            rv = s_q.gate_control;
            rv[tgc_pkg::TGC_BIT_GATE_LEVEL] = proc_gate;
         end
         tgc_pkg::TGC_ADDR_COUNT_LOW:    rv = s_q.count[7:0];
         tgc_pkg::TGC_ADDR_COUNT_HIGH:   rv = s_q.count[15:8];
         tgc_pkg::TGC_ADDR_COUNTER_CTRL: rv = {7'h00, s_q.counter_on};
         tgc_pkg::TGC_ADDR_INT_STATUS:   rv = {6'h00, s_q.int_status};
         tgc_pkg::TGC_ADDR_INT_MASK:     rv = {6'h00, s_q.int_mask};
         default:                        rv = 8'h00;
      endcase
      if (rd_acc) begin
         s_d.rdata = {24'h000000, rv};
      end
      s_d.wr_pend = acc & hwrite;
      if (acc) begin
         s_d.wr_addr = a_addr;
      end
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '{pin_sync: 3'h0, pin_level: 1'b0, pol_prev: 1'b0, path_prev: 1'b0,
                  toggle_ff: 1'b0, sp_state: tgc_pkg::TGC_SP_IDLE,
                  gate_control: tgc_pkg::TGC_RST_GATE_CONTROL, counter_on: 1'b0,
                  count: tgc_pkg::TGC_RST_COUNT, int_status: tgc_pkg::TGC_RST_INT,
                  int_mask: tgc_pkg::TGC_RST_INT, irq: 1'b0, wr_pend: 1'b0,
                  wr_addr: 8'h00, rdata: 32'h00000000};
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs; zero-wait slave, always OKAY
   assign hrdata    = s_q.rdata;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign irq       = s_q.irq;

   // Checks on the gate path, counter and registers
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_counter_off_hold: assert property (
      !s_q.counter_on && !wr_lo && !wr_hi |=> s_q.count == $past(s_q.count))
      else $error("count moved while counter off");
   a_gate_blocks_count: assert property (
      s_q.counter_on && ge && !proc_gate && !wr_lo && !wr_hi
      |=> s_q.count == $past(s_q.count))
      else $error("count moved while gate closed");
   a_gate_open_count: assert property (
      s_q.counter_on && ge && proc_gate && count_tick && !wr_lo && !wr_hi
      |=> s_q.count == $past(s_q.count) + 16'h0001)
      else $error("count did not advance with gate open");
   a_polarity_pin: assert property (
      !tm && !spm && ss == tgc_pkg::TGC_SRC_PIN |-> proc_gate == (pol ~^ s_q.pin_level))
      else $error("polarity not applied to pin level");
   a_toggle_flip: assert property (
      tm && !wr_gc && pol_rise |=> s_q.toggle_ff != $past(s_q.toggle_ff))
      else $error("toggle stage missed a rising edge");
   a_toggle_cleared: assert property (
      !tm ##1 !tm |-> !s_q.toggle_ff)
      else $error("toggle stage not cleared");
   a_toggle_path: assert property (
      tm && !spm |-> proc_gate == s_q.toggle_ff)
      else $error("gate not taken from toggle stage");
   a_single_bypass: assert property (
      !spm |-> proc_gate == path_level)
      else $error("single-pulse logic touched the gate");
   a_go_hw_clear: assert property (
      acq_done && !go_set_wr |=> !go ##1 s_q.sp_state == tgc_pkg::TGC_SP_IDLE)
      else $error("go flag not cleared after acquisition");
   a_go_held_meas: assert property (
      sp_gate && go && path_level && !wr_gc |=> go)
      else $error("go flag dropped during measurement");
   a_level_read: assert property (
      rd_acc && a_addr == tgc_pkg::TGC_ADDR_GATE_CONTROL
      |=> hrdata[tgc_pkg::TGC_BIT_GATE_LEVEL] == $past(proc_gate))
      else $error("gate level bit wrong");
   a_level_no_enable: assert property (
      !ge && !spm && !tm |-> proc_gate == pol_level)
      else $error("gate level depends on gate enable");
   a_reserved_source: assert property (
      ss == 2'h3 |-> !sel_level)
      else $error("reserved source not closed");
   a_byte_read: assert property (
      rd_acc && a_addr == tgc_pkg::TGC_ADDR_COUNT_HIGH
      |=> hrdata[7:0] == $past(s_q.count[15:8]))
      else $error("high byte read wrong");

   c_acq_done:  cover property (acq_done ##1 !go);
   c_toggle:    cover property (tm && pol_rise ##1 s_q.toggle_ff);
   c_overflow:  cover property (overflow ##1 irq);
   c_status_rd: cover property (irq ##1 rd_acc && a_addr == tgc_pkg::TGC_ADDR_INT_STATUS);

endmodule

`default_nettype wire

// ===== timer_gate_control_test.sv
`timescale 1ns/10ps
`default_nettype none

module timer_gate_control_test;
   localparam logic [7:0] GC = tgc_pkg::TGC_ADDR_GATE_CONTROL;
   localparam logic [7:0] LO = tgc_pkg::TGC_ADDR_COUNT_LOW;
   localparam logic [7:0] HI = tgc_pkg::TGC_ADDR_COUNT_HIGH;
   localparam logic [7:0] CT = tgc_pkg::TGC_ADDR_COUNTER_CTRL;
   localparam logic [7:0] ST = tgc_pkg::TGC_ADDR_INT_STATUS;
   localparam logic [7:0] MK = tgc_pkg::TGC_ADDR_INT_MASK;

   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        gate_pin;
   logic        other_timer_ovf;
   logic        comparator_sync_output;
   logic        count_tick;
   logic        irq;
   logic [31:0] rd;
   int          n_errors;
   int          check_count;
   int          cnt;
   int          k;
   int          r;

   tgc_top #(.COUNT_W(16)) uut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .gate_pin(gate_pin),
      .other_timer_ovf(other_timer_ovf), .comparator_sync_output(comparator_sync_output),
      .count_tick(count_tick), .irq(irq)
   );

   // Bus clock, 40 ns period
   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end

   // Verdict and end of run
   task automatic results();
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Compare one value against the model
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Bounded wait for hready at a rising edge
   task automatic wait_ready();
      int i;
      i = 0;
      do begin
         @(posedge hclk);
         i++;
      end while (hreadyout !== 1'b1 && i < 20);
      if (hreadyout !== 1'b1) begin
         n_errors++;
         results();
      end
   endtask

   // One single AHB-Lite word transfer
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h000000, a};
      htrans <= tgc_pkg::TGC_HTRANS_NONSEQ;
      hwrite <= w;
      wait_ready();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
      // Slave must always answer OKAY
      check({31'h0, hresp}, 32'h00000000);
   endtask

   task automatic wr(input logic [7:0] a, input int d);
      bus(1'b1, a, 32'(d));
   endtask

   task automatic rdc(input logic [7:0] a, input int e);
      bus(1'b0, a, 32'h00000000);
      check(rd, 32'(e));
   endtask

   // Drive the three gate sources, then let the gate path settle
   task automatic setin(input int p, input int o, input int c);
      @(posedge hclk);
      gate_pin               <= p[0];
      other_timer_ovf        <= o[0];
      comparator_sync_output <= c[0];
      repeat (6) @(posedge hclk);
   endtask

   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge hclk);
         count_tick <= 1'b1;
         @(posedge hclk);
         count_tick <= 1'b0;
      end
   endtask

   // Model of the processed gate level for plain gating
   function automatic int lvl(int s, int p, int r3);
      int raw;
      raw = (s == 0) ? r3 & 1 : (s == 1) ? (r3 >> 1) & 1 : (s == 2) ? (r3 >> 2) & 1 : 0;
      return raw ^ (1 - p);
   endfunction

   task automatic irqchk(input int e);
      repeat (3) @(posedge hclk);
      check({31'h0, irq}, 32'(e));
   endtask

   // Main sequence
   initial begin
      hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'h0; hwrite = 1'b0;
      hsize = 3'h2; hwdata = '0; gate_pin = 1'b0; other_timer_ovf = 1'b0;
      comparator_sync_output = 1'b0; count_tick = 1'b0; n_errors = 0; check_count = 0;
      void'($urandom(69));
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      rdc(GC, 32'h04);
      rdc(LO, 0);
      rdc(8'h20, 0);
      // Source, polarity and enable sweep with random source levels
      for (int s = 0; s < 4; s++) begin
         for (int p = 0; p < 2; p++) begin
            for (int j = 0; j < 3; j++) begin
               r = $urandom % 8;
               k = (($urandom % 2) << 7) | (p << 6) | s;
               wr(GC, k);
               setin(r & 1, (r >> 1) & 1, r >> 2);
               rdc(GC, k | (lvl(s, p, r) << 2));
            end
         end
      end
      // Count bytes and gated counting
      cnt = $urandom % 32768;
      wr(LO, cnt & 255);
      wr(HI, cnt >> 8);
      wr(GC, 8'hC1);
      setin(0, 0, 0);
      ticks(3);
      wr(CT, 1);
      ticks(3);
      setin(0, 1, 0);
      k = 1 + $urandom % 8;
      ticks(k);
      cnt = cnt + k;
      wr(GC, 8'h41);
      setin(0, 0, 0);
      ticks(2);
      cnt = cnt + 2;
      rdc(LO, cnt & 255);
      rdc(HI, cnt >> 8);
      // Overflow event, masked then unmasked, cleared by read
      wr(LO, 8'hFF);
      wr(HI, 8'hFF);
      ticks(1);
      irqchk(0);
      wr(MK, 1);
      irqchk(1);
      rdc(ST, 1);
      irqchk(0);
      rdc(HI, 0);
      wr(CT, 0);
      // Toggle flip-flop holds the gate for a whole period
      wr(GC, 8'h61);
      rdc(GC, 8'h61);
      for (int t = 1; t < 4; t++) begin
         setin(0, 1, 0);
         setin(0, 0, 0);
         rdc(GC, 8'h61 | ((t & 1) << 2));
      end
      wr(GC, 8'h41);
      rdc(GC, 8'h41);
      wr(GC, 8'h61);
      rdc(GC, 8'h61);
      // Single pulse: closed unless armed, then one pulse clears go
      wr(MK, 2);
      wr(GC, 8'h51);
      setin(0, 1, 0);
      rdc(GC, 8'h51);
      setin(0, 0, 0);
      wr(GC, 8'h59);
      rdc(GC, 8'h59);
      setin(0, 1, 0);
      rdc(GC, 8'h5D);
      setin(0, 0, 0);
      rdc(GC, 8'h51);
      irqchk(1);
      rdc(ST, 2);
      irqchk(0);
      // Second reset in mid-run restores the reset values
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rdc(GC, 32'h04);
      rdc(MK, 0);
      rdc(ST, 0);
      irqchk(0);
      results();
   end
endmodule

`default_nettype wire
